//--- core/wdg_top.sv
// Watchdog downcounter with APB register access and stop/wait gating
// Behaviour
// - Any reset loads the watchdog register with 0xfe: disarmed, longest period.
// - Writing zero to the software-reset bit raises a reset at once.
// - Register bit 7 is counter LSB; bit 2 is the top period bit.
// - Reset fires when counter bit 6 falls to zero.
// - Six period bits select 64 periods from 3072 to 196608 cycles.
// - Software writes the period bits and the counter loads them.
// - Hardware option forces the activation bit to one permanently.
// - Software option: writing one arms; only reset disarms.
// - Disarmed, the counter is a free 7-bit timer without reset.
// - At least 28 instructions pass after arming or reset before expiry.
// - With interrupts globally off, NMI is serviced but never wakes the core.
// - Armed, the counter decrements and resets the device unless reloaded.
// - Hardware option without stop control turns stop into wait.
// - With stop control, pin low gives wait, pin high freezes and stops.
// - Leaving stop on an interrupt resumes counting from the frozen value.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module wdg_top
  import wdg_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Option pins
  input wire logic HW_OPTION,
  input wire logic EXT_STOP_OPTION,
  // Stop-gating and interrupt pins
  input wire logic NMI_PIN,
  input wire logic IRQ_REQ,
  input wire logic NMI_ACK,
  // Core status
  output logic WDG_RESET,
  output logic STOP_MODE,
  output logic WAIT_MODE,
  output logic NMI_REQ,
  output logic WAKE
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic nmi_prev;
    logic nmi_latch;
    logic active;
    logic [CNT_W-1:0] cnt;
    logic irq_en;
    mode_type mode;
    logic wdg_reset;
    logic wake;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

  state_type r;
  state_type next_r;
  logic tick;
  logic wdr_write;
  logic hw_opt;
  logic ext_opt;
  logic nmi_s;

  // Option pins and the stop-gating pin come from outside: two flops first
  assign hw_opt = r.sync[0];
  assign ext_opt = r.sync[1];
  assign nmi_s = r.sync[2];

  // ----------------------------------------------------------------
  // Bit order helpers
  // ----------------------------------------------------------------
  // Register view of the counter: reversed and shifted
  function automatic logic [7:0] to_reg(input logic [CNT_W-1:0] c, input logic act);
    logic [7:0] v;
    v = '0;
    v[ACT_BIT] = act;
    v[SWRST_BIT] = c[CNT_W-1];
    for (int i = 0; i < PERIOD_W; i++) begin
      v[PERIOD_TOP-i] = c[i];
    end
    return v;
  endfunction : to_reg

  function automatic logic [CNT_W-1:0] from_reg(input logic [7:0] v);
    logic [CNT_W-1:0] c;
    c = '0;
    c[CNT_W-1] = v[SWRST_BIT];
    for (int i = 0; i < PERIOD_W; i++) begin
      c[i] = v[PERIOD_TOP-i];
    end
    return c;
  endfunction : from_reg

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  assign wdr_write = PSEL && PENABLE && r.pready && PWRITE && (PADDR == WDR_ADDR);

  // Restart on reload
  // A reload or arming restarts the interval, so the first step is never short
  // Fixed step interval
  wdg_prescaler #(
    .CYCLES(PRESCALE)
  ) u_prescaler (
    .CLK(CLK),
    .RST_N(RST_N),
    .enable(r.mode != STOPPED),
    .restart(wdr_write),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic setup;
    logic access;
    logic pwr_write;
    logic mapped;
    logic nmi_fall;
    logic [7:0] wr_byte;
    setup = PSEL && !PENABLE;
    access = PSEL && PENABLE && r.pready;
    pwr_write = access && PWRITE && (PADDR == PWR_ADDR);
    mapped = (PADDR == WDR_ADDR) || (PADDR == PWR_ADDR);
    wr_byte = PWDATA[7:0];
    next_r = r;
    next_r.meta = {NMI_PIN, EXT_STOP_OPTION, HW_OPTION};
    next_r.sync = r.meta;
    next_r.nmi_prev = nmi_s;
    next_r.wdg_reset = 1'b0;
    next_r.wake = 1'b0;

    if (hw_opt) begin
      next_r.active = 1'b1;
    end

    if (tick && r.mode != STOPPED) begin
      next_r.cnt = r.cnt - 1'b1;
      if (r.active && r.cnt[CNT_W-1] && !next_r.cnt[CNT_W-1]) begin
        next_r.wdg_reset = 1'b1;
      end
    end

    if (wdr_write) begin
      next_r.cnt = from_reg(wr_byte);
      next_r.active = r.active || wr_byte[ACT_BIT] || hw_opt;
      if (!wr_byte[SWRST_BIT]) begin
        next_r.wdg_reset = 1'b1;
      end
    end

    // Falling edge on the pin latches an NMI; set beats acknowledge
    nmi_fall = r.nmi_prev && !nmi_s;
    if (NMI_ACK) begin
      next_r.nmi_latch = 1'b0;
    end
    if (nmi_fall) begin
      next_r.nmi_latch = 1'b1;
    end

    if (pwr_write) begin
      next_r.irq_en = PWDATA[IRQ_EN_BIT];
    end

    case (r.mode)
      RUN: begin
        if (pwr_write && PWDATA[WAIT_BIT]) begin
          next_r.mode = WAITING;
        end else if (pwr_write && PWDATA[STOP_BIT]) begin
          if (next_r.active && !(ext_opt && nmi_s)) begin
            next_r.mode = WAITING;
          end else begin
            next_r.mode = STOPPED;
          end
        end
      end
      WAITING, STOPPED: begin
        if (r.irq_en && (IRQ_REQ || r.nmi_latch)) begin
          next_r.mode = RUN;
          next_r.wake = 1'b1;
        end
      end
      default: begin
        next_r.mode = RUN;
      end
    endcase

    // No wait state: answer is prepared in the setup cycle
    next_r.pready = setup;
    next_r.pslverr = setup && !mapped;
    next_r.prdata = '0;
    if (setup && PADDR == WDR_ADDR) begin
      next_r.prdata[7:0] = to_reg(r.cnt, r.active);
    end else if (setup && PADDR == PWR_ADDR) begin
      next_r.prdata[IRQ_EN_BIT] = r.irq_en;
      next_r.prdata[STOP_BIT] = (r.mode == STOPPED);
      next_r.prdata[WAIT_BIT] = (r.mode == WAITING);
      next_r.prdata[ARMED_BIT] = r.active;
      next_r.prdata[NMI_BIT] = r.nmi_latch;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= '0;
      r.cnt <= from_reg(WDR_RESET);
      r.active <= WDR_RESET[ACT_BIT];
      r.mode <= RUN;
    end else begin
      r <= next_r;
    end
  end

  assign PREADY = r.pready;
  assign PRDATA = r.prdata;
  assign PSLVERR = r.pslverr;
  assign WDG_RESET = r.wdg_reset;
  assign STOP_MODE = (r.mode == STOPPED);
  assign WAIT_MODE = (r.mode == WAITING);
  assign NMI_REQ = r.nmi_latch;
  assign WAKE = r.wake;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic wr_d;
  logic [7:0] wr_byte_d;
  always_ff @(posedge CLK) begin
    wr_d <= wdr_write;
    wr_byte_d <= PWDATA[7:0];
  end

  reset_value_a: assert property ($rose(RST_N) |-> to_reg(r.cnt, r.active) == WDR_RESET)
    else $error("watchdog register not 0xfe after reset");
  sw_reset_a: assert property (wdr_write && !PWDATA[SWRST_BIT] |=> WDG_RESET)
    else $error("clearing software-reset bit gave no reset");
  bit_order_a: assert property (wr_d |-> to_reg(r.cnt, 1'b0) == {wr_byte_d[7:1], 1'b0})
    else $error("written period bits not mapped in reverse order");
  trigger_a: assert property ($rose(WDG_RESET) && !$past(wdr_write)
    |-> $past(r.active) && $past(r.cnt[CNT_W-1]) && !r.cnt[CNT_W-1])
    else $error("watchdog reset without bit 6 falling");
  hw_force_a: assert property (hw_opt |=> r.active)
    else $error("hardware option did not force activation");
  stay_armed_a: assert property (r.active |=> r.active)
    else $error("watchdog disarmed without reset");
  timer_quiet_a: assert property (!r.active && !wdr_write |=> !WDG_RESET)
    else $error("disarmed timer raised a reset");
  stop_freeze_a: assert property (STOP_MODE && !wdr_write |=> $stable(r.cnt))
    else $error("counter moved while stopped");
  no_wake_a: assert property (!r.irq_en && r.mode != RUN |=> !WAKE)
    else $error("woke with interrupts globally off");
  step_rate_a: assert property (tick |=> !tick [*8])
    else $error("prescaler steps too close together");

  cov_expire_c: cover property (r.active && tick && r.cnt == {1'b1, {PERIOD_W{1'b0}}});
  cov_sw_reset_c: cover property (wdr_write && !PWDATA[SWRST_BIT]);
  cov_stop_wake_c: cover property (STOP_MODE ##1 WAKE);
  cov_wait_c: cover property ($rose(WAIT_MODE));
endmodule : wdg_top

//--- core/wdg_pkg.sv
// Constants, register layout and state types shared by the watchdog files
package wdg_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] WDR_ADDR = 12'h0d8;
  localparam logic [11:0] PWR_ADDR = 12'h0dc;
  localparam int ADDR_W = 12;
  // ----------------------------------------------------------------
  // Watchdog register fields
  // ----------------------------------------------------------------
  localparam logic [7:0] WDR_RESET = 8'hfe;
  localparam int ACT_BIT = 0;
  localparam int SWRST_BIT = 1;
  localparam int PERIOD_TOP = 7;
  localparam int CNT_W = 7;
  localparam int PERIOD_W = 6;
  // ----------------------------------------------------------------
  // Power control register fields
  // ----------------------------------------------------------------
  localparam int IRQ_EN_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int WAIT_BIT = 2;
  localparam int ARMED_BIT = 3;
  localparam int NMI_BIT = 4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PRESCALE_CYCLES = 3072;
  localparam int PRESCALE_W = 12;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RUN, WAITING, STOPPED} mode_type;
endpackage : wdg_pkg

//--- core/wdg_prescaler.sv
// Fixed prescaler giving one downcounter step per interval
`timescale 1ns/100ps
module wdg_prescaler
  import wdg_pkg::*;
#(
  parameter int CYCLES = PRESCALE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Control
  input wire logic enable,
  input wire logic restart,
  // Step pulse
  output logic tick
);
  typedef struct packed {
    logic [PRESCALE_W-1:0] count;
    logic tick;
  } pre_state_type;

  localparam logic [PRESCALE_W-1:0] LAST = PRESCALE_W'(CYCLES - 1);

  pre_state_type r;
  pre_state_type next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (restart) begin
      next_r.count = '0;
    end else if (enable) begin
      if (r.count == LAST) begin
        next_r.count = '0;
        next_r.tick = 1'b1;
      end else begin
        next_r.count = r.count + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : wdg_prescaler

//--- sim/wdg_core_model.sv
// Model of the core answering the NMI and driving the stop-gating pin
`timescale 1ns/100ps
module wdg_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic idle,
  input wire logic irq_go,
  input wire logic slow,
  // Design side
  input wire logic nmi_req,
  output logic nmi_pin,
  output logic irq_req,
  output logic nmi_ack
);
  logic [2:0] wait_cnt;
  assign nmi_pin = idle;
  assign irq_req = irq_go;
  // NMI serviced anyway
  // Slow answer leaves the latch set long enough to watch it
  always_ff @(posedge clk) begin
    if (!rst_n || !nmi_req || nmi_ack) begin
      wait_cnt <= 3'h0;
      nmi_ack <= 1'h0;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
      nmi_ack <= (wait_cnt == (slow ? 3'h5 : 3'h0));
    end
  end
endmodule : wdg_core_model

//--- sim/digital_watchdog_downcounter_bench.sv
// Self-checking bench for the watchdog downcounter
`timescale 1ns/100ps
module digital_watchdog_downcounter_bench;
  import wdg_pkg::*;
  localparam int P = 16;
  localparam int LIMIT = 20000;
  logic clk, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hw = 1'h0, ext = 1'h0;
  logic rst_n = 1'h0, idle = 1'h1, irq_go = 1'h0, slow = 1'h0, er, pready, pslverr;
  logic wdg_reset, stop_mode, wait_mode, nmi_req, wake, nmi_pin, irq_req, nmi_ack;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [6:0] c;
  int err_count = 0, n_checks = 0, cycles = 0, resets = 0, wakes = 0, t, n0;
  int tv[3] = '{0, 63, 0};
  integer seed = 32'h973e5f5a;
  // Chip reset also comes back from the watchdog
  wire logic rst_line = rst_n & ~wdg_reset;

  wdg_top #(.PRESCALE(P)) DUT (
    .CLK(clk), .RST_N(rst_line), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .HW_OPTION(hw), .EXT_STOP_OPTION(ext), .NMI_PIN(nmi_pin), .IRQ_REQ(irq_req),
    .NMI_ACK(nmi_ack), .WDG_RESET(wdg_reset), .STOP_MODE(stop_mode),
    .WAIT_MODE(wait_mode), .NMI_REQ(nmi_req), .WAKE(wake)
  );
  wdg_core_model core (
    .clk(clk), .rst_n(rst_line), .idle(idle), .irq_go(irq_go), .slow(slow),
    .nmi_req(nmi_req), .nmi_pin(nmi_pin), .irq_req(irq_req), .nmi_ack(nmi_ack)
  );

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // ----
  // Helpers
  // ----
  function automatic logic [7:0] to_reg(input logic [6:0] n, input logic act);
    to_reg = {n[0], n[1], n[2], n[3], n[4], n[5], n[6], act};
  endfunction : to_reg

  function automatic logic [6:0] to_cnt(input logic [7:0] r);
    to_cnt = {r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
  endfunction : to_cnt

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_in

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    // Look mid-cycle so the answer is read while it stands, not as it leaves
    do @(negedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic do_reset(input logic h, input logic x);
    rst_n <= 1'h0;
    hw <= h;
    ext <= x;
    wt(3);
    rst_n <= 1'h1;
    wt(4);
  endtask : do_reset

  task automatic conclude();
    if (err_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Hang guard; the run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    resets += int'(wdg_reset === 1'h1);
    wakes += int'(wake === 1'h1);
    if (cycles == LIMIT) begin
      err_count++;
      conclude();
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    wt(1);
    do_reset(1'h0, 1'h0);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hfe);
    apb(1'h0, 12'h0e0, 8'h00);
    chk({rd[31:1], er}, 32'h1);
    repeat (6) begin
      c = 7'h40 | 7'($random(seed));
      apb(1'h1, WDR_ADDR, to_reg(c, 1'h0));
      apb(1'h0, WDR_ADDR, 8'h00);
      chk(rd, {24'h0, to_reg(c, 1'h0)});
    end
    c = 7'h40 | 7'($random(seed));
    n0 = resets;
    apb(1'h1, WDR_ADDR, to_reg(c, 1'h0));
    t = int'(c[5:0]) + 2;
    wt(t * P + P / 2 - 3);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, {24'h0, to_reg(7'h3e, 1'h0)});
    chk(resets, n0);
    apb(1'h1, WDR_ADDR, 8'hff);
    apb(1'h1, WDR_ADDR, 8'hfe);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hff);
    n0 = resets;
    apb(1'h1, WDR_ADDR, 8'hfd);
    wt(4);
    chk(resets, n0 + 1);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hfe);
    tv[2] = 1 + {$random(seed)} % 62;
    foreach (tv[i]) begin
      c = 7'h40 | 7'(tv[i]);
      apb(1'h1, WDR_ADDR, to_reg(c, 1'h1));
      // Reload half way: expiry counts from the last reload
      if (i == 1) begin
        wt(P * 32);
        apb(1'h1, WDR_ADDR, to_reg(c, 1'h1));
      end
      t = 0;
      while (wdg_reset !== 1'h1 && t < 2000) begin
        @(posedge clk);
        t++;
      end
      chk_in(t, (tv[i] + 1) * P, (tv[i] + 1) * P + 3);
      wt(4);
      apb(1'h0, WDR_ADDR, 8'h00);
      chk(rd, 32'hfe);
    end
    do_reset(1'h1, 1'h1);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hff);
    apb(1'h1, WDR_ADDR, 8'hfe);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hff);
    apb(1'h1, PWR_ADDR, 8'h03);
    wt(2);
    chk(stop_mode, 1'h1);
    wt(3 * P);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk(rd, 32'hff);
    n0 = wakes;
    irq_go <= 1'h1;
    wt(3);
    irq_go <= 1'h0;
    wt(37);
    chk(wakes, n0 + 1);
    apb(1'h0, WDR_ADDR, 8'h00);
    chk_in(int'(to_cnt(rd[7:0])), 'h7b, 'h7d);
    apb(1'h1, WDR_ADDR, 8'hff);
    idle <= 1'h0;
    wt(10);
    apb(1'h1, PWR_ADDR, 8'h03);
    wt(2);
    chk({stop_mode, wait_mode}, 2'h1);
    idle <= 1'h1;
    do_reset(1'h1, 1'h0);
    slow <= 1'h1;
    apb(1'h1, PWR_ADDR, 8'h02);
    wt(2);
    chk({stop_mode, wait_mode}, 2'h1);
    n0 = wakes;
    idle <= 1'h0;
    wt(5);
    chk(nmi_req, 1'h1);
    wt(10);
    chk({wakes, wait_mode}, {n0, 1'h1});
    conclude();
  end
endmodule : digital_watchdog_downcounter_bench
